/* src/hsr_cyc_eng.sv */
// One chip-enable framed memory cycle on the asynchronous pins.
`timescale 1ns/1ns
`default_nettype none
module hsr_cyc_eng
  import hsr_pkg::*;
(
  input wire logic clk_in, // 25 MHz clock
  input wire logic rst_b_in, // async reset, active low
  hsr_cyc_if.eng cif // sequencer side
);
  typedef enum logic [1:0] {ENG_IDLE, ENG_SETUP, ENG_STROBE, ENG_HOLD} hsr_eng_t;
  hsr_eng_t state_reg, state_next;
  logic [STB_W-1:0] stb_reg;
  logic write_reg;
  logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg;
  wire logic stb_end = (state_reg == ENG_STROBE) && (stb_reg == STB_LAST);

  always_comb begin
    case (state_reg)
      ENG_IDLE: state_next = cif.req ? ENG_SETUP : ENG_IDLE;
      ENG_SETUP: state_next = ENG_STROBE;
      ENG_STROBE: state_next = stb_end ? ENG_HOLD : ENG_STROBE;
      ENG_HOLD: state_next = ENG_IDLE;
      default: state_next = ENG_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
    end else begin
      dq_s1_reg <= cif.dq_pin;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= ENG_IDLE;
      stb_reg <= 3'h0;
      write_reg <= 1'b0;
      cif.ce_b <= 1'b1;
      cif.oe_b <= 1'b1;
      cif.we_b <= 1'b1;
      cif.pin_addr <= 11'h000;
      cif.dq_o <= 8'h00;
      cif.dq_oe <= 1'b0;
      cif.done <= 1'b0;
      cif.rdata <= 8'h00;
    end else begin
      state_reg <= state_next;
      cif.done <= (state_reg == ENG_HOLD);
      stb_reg <= (state_reg == ENG_STROBE) ? stb_reg + 3'h1 : 3'h0;
      case (state_reg)
        ENG_IDLE: if (cif.req) begin
          cif.pin_addr <= cif.addr;
          cif.dq_o <= cif.wdata;
          write_reg <= cif.write;
        end
        ENG_SETUP: begin
          // every access framed by chip enable
          cif.ce_b <= 1'b0;
          cif.we_b <= !write_reg;
          // sequence steps are reads
          // Output enable stays high on writes so the bus never contends.
          cif.oe_b <= write_reg;
          cif.dq_oe <= write_reg;
        end
        ENG_STROBE: if (stb_end) begin
          // data driven through the trailing edge
          cif.ce_b <= 1'b1;
          cif.we_b <= 1'b1;
          cif.oe_b <= 1'b1;
          cif.rdata <= dq_s2_reg;
        end
        ENG_HOLD: cif.dq_oe <= 1'b0;
        default: cif.dq_oe <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_addr_stable_write: assert property (
    !cif.we_b && $past(!cif.we_b) |-> $stable(cif.pin_addr))
    else $error("address moved during a write");
  chk_strobe_width: assert property (
    $fell(cif.ce_b) |-> !cif.ce_b [*4] ##1 cif.ce_b)
    else $error("chip enable pulse width wrong");
  chk_we_high_read: assert property (
    !cif.oe_b |-> cif.we_b && !cif.dq_oe)
    else $error("read cycle with write enable low or bus driven");
  chk_data_hold_write: assert property (
    $rose(cif.we_b) |-> cif.dq_oe && $stable(cif.dq_o))
    else $error("write data not held at trailing edge");
  chk_we_inside_ce: assert property (
    !cif.we_b |-> !cif.ce_b && cif.oe_b)
    else $error("write enable outside chip enable or with output enable");
  cov_write_cycle: cover property ($rose(cif.we_b));
endmodule : hsr_cyc_eng
`default_nettype wire

/* src/hsr_cyc_if.sv */
// Link between the host sequencer and its memory cycle engine.
`timescale 1ns/1ns
`default_nettype none
interface hsr_cyc_if;
  import hsr_pkg::*;
  logic req;
  logic write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic done;
  logic [DATA_W-1:0] rdata;
  logic ce_b;
  logic oe_b;
  logic we_b;
  logic [ADDR_W-1:0] pin_addr;
  logic [DATA_W-1:0] dq_o;
  logic dq_oe;
  logic [DATA_W-1:0] dq_pin;
  modport ctl (output req, write, addr, wdata, dq_pin,
               input done, rdata, ce_b, oe_b, we_b, pin_addr, dq_o, dq_oe);
  modport eng (input req, write, addr, wdata, dq_pin,
               output done, rdata, ce_b, oe_b, we_b, pin_addr, dq_o, dq_oe);
endinterface : hsr_cyc_if
`default_nettype wire

/* src/hsr_host.sv */
// Host controller for a 2K x 8 memory with a nonvolatile shadow copy.
//
// Contract
// - Host keeps address stable from before write until write ends.
// - Store needs reads at 000, 555, 2AA, 7FF, 0F0, 70F in order.
// - Recall needs the same five reads then a read at 70E.
// - Each sequence step is a read framed by a chip-enable pulse.
// - Sequence uses reads only; output enable may stay high.
// - Host keeps write or chip enable high while power-up recall runs.
// - Host holds write enable high during all six sequence reads.
`timescale 1ns/1ns
`default_nettype none
module hsr_host
  import hsr_pkg::*;
#(
  parameter logic [CNT_W-1:0] STORE_CYC_P = STORE_CYC, // store busy time
  parameter logic [CNT_W-1:0] RESTORE_CYC_P = RESTORE_CYC // power-up recall
) (
  input wire logic clk_in, // 25 MHz clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic cmd_valid_in, // command request
  input wire logic [1:0] cmd_op_in, // read, write, store, recall
  input wire logic [ADDR_W-1:0] cmd_addr_in, // byte address
  input wire logic [DATA_W-1:0] cmd_wdata_in, // write data
  output logic cmd_ready_out, // command taken when valid and ready
  output logic rsp_valid_out, // one-cycle completion pulse
  output logic [DATA_W-1:0] rsp_rdata_out, // read data
  output logic nv_busy_out, // store, recall, restore or power-down in progress
  input wire logic pwr_good_in, // supply above switching level
  output logic mem_ce_b_out, // chip enable, active low
  output logic mem_oe_b_out, // output enable, active low
  output logic mem_we_b_out, // write enable, active low
  output logic [ADDR_W-1:0] mem_addr_out, // address pins
  input wire logic [DATA_W-1:0] data_io_in, // data bus level
  output logic [DATA_W-1:0] data_io_out, // data bus drive value
  output logic data_io_oe_out // high while host drives data bus
);
  typedef enum logic [2:0] {
    M_PWRDN, M_RESTORE, M_IDLE, M_ACC, M_SEQ, M_NVWAIT
  } hsr_state_t;

  hsr_cyc_if cif ();
  hsr_cyc_eng u_eng (.clk_in(clk_in), .rst_b_in(rst_b_in), .cif(cif));

  hsr_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [2:0] idx_reg, idx_next;
  logic [1:0] op_reg, op_next;
  logic req_reg, req_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic rsp_next;
  logic [DATA_W-1:0] rdata_next;
  logic pg_s1_reg, pg_s2_reg;

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  wire logic take_cmd = (state_reg == M_IDLE) && cmd_valid_in &&
                        cmd_ready_out;
  wire logic op_nv = cmd_op_in[1];
  wire logic recall_sel = (op_reg == OP_RECALL);
  wire logic [CNT_W-1:0] nv_limit = recall_sel ? RECALL_CYC : STORE_CYC_P;
  wire logic nv_end = (cnt_reg + CNT_ONE) >= nv_limit;
  wire logic restore_end = (cnt_reg + CNT_ONE) >= RESTORE_CYC_P;
  wire logic seq_last = (idx_reg == SEQ_LAST_IDX);
  wire logic [2:0] idx_inc = idx_reg + 3'h1;

  assign cif.req = req_reg;
  assign cif.write = (op_reg == OP_WRITE);
  assign cif.addr = addr_reg;
  assign cif.wdata = wdata_reg;
  assign cif.dq_pin = data_io_in;
  assign mem_ce_b_out = cif.ce_b;
  assign mem_oe_b_out = cif.oe_b;
  assign mem_we_b_out = cif.we_b;
  assign mem_addr_out = cif.pin_addr;
  assign data_io_out = cif.dq_o;
  assign data_io_oe_out = cif.dq_oe;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    op_next = op_reg;
    req_next = 1'b0;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rsp_next = 1'b0;
    rdata_next = rsp_rdata_out;
    case (state_reg)
      M_PWRDN: begin
        cnt_next = 20'h00000;
        // power return triggers the automatic recall
        if (pg_s2_reg) begin
          state_next = M_RESTORE;
        end
      end
      M_RESTORE: begin
        // strobes held high until restore ends
        if (!pg_s2_reg) begin
          state_next = M_PWRDN;
        end else if (restore_end) begin
          state_next = M_IDLE;
        end else begin
          cnt_next = cnt_reg + CNT_ONE;
        end
      end
      M_IDLE: begin
        if (!pg_s2_reg) begin
          state_next = M_PWRDN;
        end else if (take_cmd) begin
          op_next = cmd_op_in;
          req_next = 1'b1;
          idx_next = 3'h0;
          wdata_next = cmd_wdata_in;
          // full eleven-bit address passed to the pins
          addr_next = op_nv ? hsr_seq_addr(3'h0, cmd_op_in[0]) : cmd_addr_in;
          state_next = op_nv ? M_SEQ : M_ACC;
        end
      end
      M_ACC: begin
        if (cif.done) begin
          rsp_next = 1'b1;
          rdata_next = cif.rdata;
          state_next = M_IDLE;
        end
      end
      M_SEQ: begin
        // store and recall addresses issued in order
        if (cif.done && seq_last) begin
          cnt_next = 20'h00000;
          state_next = M_NVWAIT;
        end else if (cif.done) begin
          // recall differs only in its last address
          idx_next = idx_inc;
          addr_next = hsr_seq_addr(idx_inc, recall_sel);
          req_next = 1'b1;
        end
      end
      M_NVWAIT: begin
        // no access until the operation time has passed
        if (nv_end) begin
          rsp_next = 1'b1;
          state_next = M_IDLE;
        end else begin
          cnt_next = cnt_reg + CNT_ONE;
        end
      end
      default: state_next = M_PWRDN;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pg_s1_reg <= 1'b0;
      pg_s2_reg <= 1'b0;
    end else begin
      pg_s1_reg <= pwr_good_in;
      pg_s2_reg <= pg_s1_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= M_PWRDN;
      cnt_reg <= 20'h00000;
      idx_reg <= 3'h0;
      op_reg <= OP_READ;
      req_reg <= 1'b0;
      addr_reg <= 11'h000;
      wdata_reg <= 8'h00;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= 8'h00;
      cmd_ready_out <= 1'b0;
      nv_busy_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      op_reg <= op_next;
      req_reg <= req_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rsp_valid_out <= rsp_next;
      rsp_rdata_out <= rdata_next;
      // no command, hence no store, while power is low
      cmd_ready_out <= (state_next == M_IDLE) && pg_s2_reg;
      nv_busy_out <= (state_next != M_IDLE) && (state_next != M_ACC);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_seq_addr_order: assert property (
    state_reg == M_SEQ && req_reg |->
      addr_reg == hsr_seq_addr(idx_reg, recall_sel))
    else $error("unlock address out of order");
  chk_seq_reads_only: assert property (
    state_reg == M_SEQ |-> mem_we_b_out && !data_io_oe_out)
    else $error("write issued inside unlock sequence");
  chk_nv_quiet: assert property (
    state_reg == M_NVWAIT |-> mem_ce_b_out && !cmd_ready_out)
    else $error("access during store or recall");
  chk_restore_quiet: assert property (
    state_reg == M_RESTORE || state_reg == M_PWRDN |->
      mem_ce_b_out && mem_we_b_out)
    else $error("strobe active during power-up recall");
  chk_store_needs_pwr: assert property (
    take_cmd |-> $past(pg_s2_reg))
    else $error("command taken while power low");
  chk_read_latency: assert property (
    take_cmd && cmd_op_in == OP_READ |-> ##9 rsp_valid_out)
    else $error("read answer not after nine cycles");
  chk_seq_to_wait: assert property (
    state_reg == M_SEQ && cif.done && seq_last |=> state_reg == M_NVWAIT
      ##1 nv_busy_out)
    else $error("sixth read not followed by busy wait");
  cov_store: cover property (state_reg == M_NVWAIT && op_reg == OP_STORE);
  cov_recall: cover property (state_reg == M_NVWAIT && op_reg == OP_RECALL);
  cov_read: cover property (rsp_valid_out && op_reg == OP_READ);
  cov_restore: cover property ($fell(nv_busy_out));
endmodule : hsr_host
`default_nettype wire

/* src/hsr_pkg.sv */
// Shared constants for the shadowed-memory host controller.
package hsr_pkg;
  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int CNT_W = 20;
  localparam int STB_W = 3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_ACCESS_NS = 45;
  localparam int T_RECALL_NS = 20000;
  localparam int T_RESTORE_NS = 550000;
  localparam int T_STORE_NS = 10000000;
  localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Two extra strobe cycles cover the data-bus synchroniser.
  localparam logic [STB_W-1:0] STB_LAST = STB_W'(ACCESS_CYC + 1);
  localparam logic [CNT_W-1:0] RECALL_CYC =
    CNT_W'((T_RECALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESTORE_CYC =
    CNT_W'((T_RESTORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STORE_CYC =
    CNT_W'((T_STORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;

  // ----------------------------------------------------------------------
  // Commands and the unlock sequence
  // ----------------------------------------------------------------------
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_STORE = 2'h2;
  localparam logic [1:0] OP_RECALL = 2'h3;
  localparam logic [2:0] SEQ_LAST_IDX = 3'h5;
  localparam logic [ADDR_W-1:0] SEQ_A0 = 11'h000;
  localparam logic [ADDR_W-1:0] SEQ_A1 = 11'h555;
  localparam logic [ADDR_W-1:0] SEQ_A2 = 11'h2AA;
  localparam logic [ADDR_W-1:0] SEQ_A3 = 11'h7FF;
  localparam logic [ADDR_W-1:0] SEQ_A4 = 11'h0F0;
  localparam logic [ADDR_W-1:0] SEQ_STORE_A5 = 11'h70F;
  localparam logic [ADDR_W-1:0] SEQ_RECALL_A5 = 11'h70E;

  function automatic logic [ADDR_W-1:0] hsr_seq_addr(input logic [2:0] idx,
                                                     input logic recall);
    case (idx)
      3'h0: hsr_seq_addr = SEQ_A0;
      3'h1: hsr_seq_addr = SEQ_A1;
      3'h2: hsr_seq_addr = SEQ_A2;
      3'h3: hsr_seq_addr = SEQ_A3;
      3'h4: hsr_seq_addr = SEQ_A4;
      default: hsr_seq_addr = recall ? SEQ_RECALL_A5 : SEQ_STORE_A5;
    endcase
  endfunction : hsr_seq_addr
endpackage : hsr_pkg

/* test/hsr_mem_model.sv */
// Behavioural model of the shadowed static memory seen by the host.
`timescale 1ns/1ns
`default_nettype none
module hsr_mem_model
  import hsr_pkg::*;
#(
  parameter int T_ACC_NS = 30,
  parameter int T_STORE_NS = 600,
  parameter int T_RECALL_NS = 15000,
  parameter int T_RESTORE_NS = 300
) (
  input wire logic ce_b_in, // chip enable, active low
  input wire logic oe_b_in, // output enable, active low
  input wire logic we_b_in, // write enable, active low
  input wire logic [ADDR_W-1:0] addr_in, // address pins
  input wire logic [DATA_W-1:0] host_d_in, // host drive value
  input wire logic host_oe_in, // host drives the bus
  input wire logic pwr_good_in, // supply above switching level
  output logic [DATA_W-1:0] bus_out // resolved data bus level
);
  // ----------------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:2047];
  logic [DATA_W-1:0] shadow [0:2047];
  logic [DATA_W-1:0] last_q = 8'h00;
  logic [ADDR_W-1:0] seq_tab [0:4] = '{11'h000, 11'h555, 11'h2AA,
                                       11'h7FF, 11'h0F0};
  logic busy = 1'b0;
  logic saw_wr = 1'b0;
  logic rd_drv;
  int step = 0;

  initial for (int i = 0; i < 2048; i++) shadow[i] = 8'(i) ^ 8'h5A;

  wire live = !busy && pwr_good_in;

  // ----------------------------------------------------------------------
  // Data bus
  // ----------------------------------------------------------------------
  // read drive
  wire rd_now = live && !ce_b_in && !oe_b_in && we_b_in;
  assign #(T_ACC_NS) rd_drv = rd_now;
  wire drv_en = host_oe_in || rd_drv;
  wire [DATA_W-1:0] drv_val = host_oe_in ? host_d_in : mem[addr_in];
  // A released bus shows the inverse of its last level, so stale data is
  // never mistaken for an answer.
  always @(drv_en or drv_val) if (drv_en) last_q = drv_val;
  assign bus_out = drv_en ? drv_val : ~last_q;

  wire wr_on = live && !ce_b_in && !we_b_in;
  always @(negedge wr_on) mem[addr_in] = bus_out;

  // ----------------------------------------------------------------------
  // Sequence detector
  // ----------------------------------------------------------------------
  always @(negedge we_b_in) saw_wr = 1'b1;

  always @(posedge ce_b_in) begin
    if (!live || saw_wr) step = 0;
    else if (step == 5 && addr_in[ADDR_W-1:1] == 10'h387) run_op(addr_in[0]);
    else if (step < 5 && addr_in == seq_tab[step]) step++;
    else step = (addr_in == 11'h000) ? 1 : 0;
    saw_wr = 1'b0;
  end

  task automatic run_op(input logic keep);
    step = 0;
    busy = 1'b1;
    if (keep) begin
      for (int i = 0; i < 2048; i++) shadow[i] = 8'hFF;
      #(T_STORE_NS);
      for (int i = 0; i < 2048; i++) shadow[i] = mem[i];
    end else begin
      for (int i = 0; i < 2048; i++) mem[i] = 8'h00;
      #(T_RECALL_NS);
      for (int i = 0; i < 2048; i++) mem[i] = shadow[i];
    end
    busy = 1'b0;
  endtask : run_op

  always @(posedge pwr_good_in) begin
    busy = 1'b1;
    #(T_RESTORE_NS);
    for (int i = 0; i < 2048; i++) mem[i] = shadow[i];
    busy = 1'b0;
  end
endmodule : hsr_mem_model
`default_nettype wire

/* test/test_shadowed_sram_store_recall.sv */
// Self-checking bench for the host controller of the shadowed memory.
`timescale 1ns/1ns
`default_nettype none
module test_shadowed_sram_store_recall
  import hsr_pkg::*;
;
  // Three recalls of about 500 cycles dominate; the rest is short.
  localparam int LIMIT = 5000;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  logic [1:0] cmd_op_in = 2'h0;
  logic [ADDR_W-1:0] cmd_addr_in = 11'h000;
  logic [DATA_W-1:0] cmd_wdata_in = 8'h00;
  logic pwr_good_in = 1'b0;
  logic cmd_ready_out, rsp_valid_out, nv_busy_out, data_io_oe_out;
  logic mem_ce_b_out, mem_oe_b_out, mem_we_b_out;
  logic [ADDR_W-1:0] mem_addr_out;
  logic [DATA_W-1:0] rsp_rdata_out, data_io_in, data_io_out;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  hsr_host #(.STORE_CYC_P(20'h00014), .RESTORE_CYC_P(20'h0000A)) i_dut (
    .clk_in, .rst_b_in, .cmd_valid_in, .cmd_op_in, .cmd_addr_in,
    .cmd_wdata_in, .cmd_ready_out, .rsp_valid_out, .rsp_rdata_out,
    .nv_busy_out, .pwr_good_in, .mem_ce_b_out, .mem_oe_b_out, .mem_we_b_out,
    .mem_addr_out, .data_io_in, .data_io_out, .data_io_oe_out);

  hsr_mem_model i_mem (.ce_b_in(mem_ce_b_out), .oe_b_in(mem_oe_b_out),
    .we_b_in(mem_we_b_out), .addr_in(mem_addr_out), .host_d_in(data_io_out),
    .host_oe_in(data_io_oe_out), .pwr_good_in, .bus_out(data_io_in));

  initial forever #20 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task automatic chk8(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk1

  task automatic wait_ready();
    while (cmd_ready_out !== 1'b1) @(negedge clk_in);
  endtask : wait_ready

  task automatic do_cmd(input logic [1:0] op, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(negedge clk_in);
    cmd_valid_in = 1'b1;
    cmd_op_in = op;
    cmd_addr_in = a;
    cmd_wdata_in = d;
    wait_ready();
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    while (rsp_valid_out !== 1'b1) @(negedge clk_in);
  endtask : do_cmd

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    do_cmd(OP_READ, a, 8'h00);
    chk8(rsp_rdata_out, e);
  endtask : rd

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_power_up();
    @(negedge clk_in);
    chk1(nv_busy_out, 1'b1);
    wait_ready();
    rd(11'h123, 8'h79);
  endtask : t_power_up

  task automatic t_rw();
    logic [ADDR_W-1:0] a [4] = '{11'h000, 11'h7FF, 11'h555, 11'h2AA};
    for (int i = 0; i < 4; i++) do_cmd(OP_WRITE, a[i], 8'hC1 + 8'(i));
    for (int i = 0; i < 4; i++) rd(a[i], 8'hC1 + 8'(i));
    rd(11'h001, 8'h5B);
  endtask : t_rw

  task automatic t_store_recall();
    do_cmd(OP_WRITE, 11'h100, 8'h3C);
    do_cmd(OP_STORE, 11'h000, 8'h00);
    chk1(nv_busy_out, 1'b0);
    do_cmd(OP_WRITE, 11'h100, 8'hC3);
    rd(11'h100, 8'hC3);
    do_cmd(OP_RECALL, 11'h000, 8'h00);
    rd(11'h100, 8'h3C);
    do_cmd(OP_RECALL, 11'h000, 8'h00);
    rd(11'h000, 8'hC1);
  endtask : t_store_recall

  task automatic t_abort();
    logic [ADDR_W-1:0] s [5] = '{11'h000, 11'h555, 11'h0F0, 11'h2AA, 11'h7FF};
    for (int i = 0; i < 2; i++) do_cmd(OP_READ, s[i], 8'h00);
    do_cmd(OP_WRITE, 11'h200, 8'h11);
    for (int i = 3; i < 5; i++) do_cmd(OP_READ, s[i], 8'h00);
    do_cmd(OP_READ, 11'h0F0, 8'h00);
    rd(11'h70F, 8'h55);
    for (int i = 0; i < 5; i++) do_cmd(OP_READ, s[i], 8'h00);
    do_cmd(OP_READ, 11'h0F0, 8'h00);
    rd(11'h70F, 8'h55);
    do_cmd(OP_WRITE, 11'h100, 8'h77);
    do_cmd(OP_RECALL, 11'h000, 8'h00);
    rd(11'h100, 8'h3C);
    rd(11'h200, 8'h5A);
  endtask : t_abort

  task automatic t_power_loss();
    do_cmd(OP_WRITE, 11'h100, 8'h99);
    @(negedge clk_in);
    pwr_good_in = 1'b0;
    repeat (5) @(negedge clk_in);
    cmd_valid_in = 1'b1;
    cmd_op_in = OP_STORE;
    repeat (20) @(negedge clk_in);
    chk1(cmd_ready_out, 1'b0);
    chk1(nv_busy_out, 1'b1);
    chk1(rsp_valid_out, 1'b0);
    cmd_valid_in = 1'b0;
    pwr_good_in = 1'b1;
    wait_ready();
    rd(11'h100, 8'h3C);
  endtask : t_power_loss

  initial begin
    repeat (16) @(negedge clk_in);
    rst_b_in = 1'b1;
    pwr_good_in = 1'b1;
    t_power_up();
    t_rw();
    t_store_recall();
    t_abort();
    t_power_loss();
    final_report();
  end
endmodule : test_shadowed_sram_store_recall
`default_nettype wire
